// ==== design/fst_lut_entries.sv ====
// Register bank and duty selection for fan speed table entries nine and ten.
// Assumes a single AHB-Lite master and a remote reading on the same clock.
//
// Function
// - Low duty resolution: duty bits 7:6 unused and read as zero.
// - High duty resolution: bits 7:6 join bits 5:0 as the duty value.
// - Extended duty bits act only when the fast PWM frequency is selected.
// - Low duty resolution: duty value is bits 5:0 of the duty register.
// - Low temperature resolution: limit bit 7 unused, reads zero; high uses it.
// - Limit spans 0..127.5 in half degrees high, 0..127 whole degrees low.
// - Reading above entry ten limit drives entry ten duty.
// - Compare uses nine reading bits in high resolution, eight in low.
// - Every table limit is non-negative; sign bit taken as zero.
// - The table offset register is added to every programmed limit.
// - Reading above entry nine limit but not entry ten limit drives entry nine duty.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
module fst_lut_entries (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,

   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,

   // Device side
   input wire logic [10:0] remote_temp,
   input wire logic [7:0] entry9_limit,
   output logic [7:0] table_duty,
   output logic table_duty_hit
);

   // Stored registers
   logic [7:0] entry9_duty_ff;
   logic [7:0] entry10_limit_ff;
   logic [7:0] entry10_duty_ff;
   logic [7:0] cfg_ff;
   logic [7:0] mode_ff;
   logic [7:0] table_ofs_ff;

   // Bus data phase state
   fst_pkg::fst_bus_state_t bus_state_ff;
   fst_pkg::fst_bus_state_t nxt_bus_state;
   logic [7:0] wr_idx_ff;
   logic [31:0] hrdata_ff;
   logic [31:0] nxt_hrdata;

   // Outputs
   logic [7:0] table_duty_ff;
   logic table_duty_hit_ff;

   // Decode helpers
   logic addr_ok;
   logic [7:0] addr_idx;
   logic xfer;
   logic wr_now;
   logic table_wr_ok;

   // Mode bits
   logic temp_hi;
   logic duty_hi;
   logic pwm_fast;

   // Decoded write strobes and register values with a landing write applied
   logic wr_cfg;
   logic wr_mode;
   logic wr_ofs;
   logic wr_duty9;
   logic wr_limit10;
   logic wr_duty10;
   logic [7:0] fwd_cfg;
   logic [7:0] fwd_mode;
   logic [7:0] fwd_ofs;
   logic [7:0] fwd_duty9;
   logic [7:0] fwd_limit10;
   logic [7:0] fwd_duty10;

   fst_entry_if tbl_if ();

   // Mode bits come from the own mode register
   assign temp_hi = mode_ff[fst_pkg::MODE_TEMP_HI_BIT];
   assign duty_hi = mode_ff[fst_pkg::MODE_DUTY_HI_BIT];
   assign pwm_fast = mode_ff[fst_pkg::MODE_PWM_FAST_BIT];

   // Readback view of a register, unused bits shown as zero
   function automatic logic [7:0] read_view(input logic [7:0] idx,
                                            input logic [7:0] d9,
                                            input logic [7:0] l10,
                                            input logic [7:0] d10,
                                            input logic [7:0] cfg,
                                            input logic [7:0] mode,
                                            input logic [7:0] ofs);
      logic [7:0] dmask;
      logic [7:0] lmask;
      dmask = mode[fst_pkg::MODE_DUTY_HI_BIT] ? 8'hFF : fst_pkg::DUTY_BASE_MASK;
      lmask = mode[fst_pkg::MODE_TEMP_HI_BIT] ? 8'hFF : fst_pkg::LIMIT_BASE_MASK;
      case (idx)
         fst_pkg::IDX_ENTRY9_DUTY: begin
            read_view = d9 & dmask;
         end
         fst_pkg::IDX_ENTRY10_LIMIT: begin
            read_view = l10 & lmask;
         end
         fst_pkg::IDX_ENTRY10_DUTY: begin
            read_view = d10 & dmask;
         end
         fst_pkg::IDX_CFG: begin
            read_view = cfg & fst_pkg::CFG_MASK;
         end
         fst_pkg::IDX_MODE: begin
            read_view = mode & fst_pkg::MODE_MASK;
         end
         fst_pkg::IDX_TABLE_OFS: begin
            read_view = ofs;
         end
         default: begin
            read_view = 8'h00;
         end
      endcase
   endfunction

   // Only word-aligned addresses in the low kilobyte map to registers
   assign addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
   assign addr_idx = haddr[9:2];

   // Address phase accepted
   assign xfer = hsel && hready &&
                 ((htrans == fst_pkg::HTRANS_NONSEQ) ||
                  (htrans == fst_pkg::HTRANS_SEQ));

   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = fst_pkg::HRESP_OKAY;
   assign hrdata = hrdata_ff;

   // Data phase tracking; writes outside the low kilobyte or unaligned fall into idle
   always_comb begin
      nxt_bus_state = fst_pkg::BUS_IDLE;
      nxt_hrdata = 32'h00000000;
      if (xfer && addr_ok && hwrite) begin
         nxt_bus_state = fst_pkg::BUS_WRITE;
      end else if (xfer && !hwrite) begin
         nxt_bus_state = fst_pkg::BUS_READ;
         if (addr_ok) begin
            nxt_hrdata = {24'h000000,
                          read_view(addr_idx, fwd_duty9, fwd_limit10, fwd_duty10,
                                    fwd_cfg, fwd_mode, fwd_ofs)};
         end
      end
   end

   // Bus state register
   always_ff @(posedge clk) begin
      if (rst) begin
         bus_state_ff <= fst_pkg::BUS_IDLE;
         wr_idx_ff <= 8'h00;
      end else begin
         bus_state_ff <= nxt_bus_state;
         if (xfer) begin
            wr_idx_ff <= addr_idx;
         end
      end
   end

   // Read data held until the next read is taken
   always_ff @(posedge clk) begin
      if (rst) begin
         hrdata_ff <= 32'h00000000;
      end else if (xfer && !hwrite) begin
         hrdata_ff <= nxt_hrdata;
      end
   end

   // Write strobe in the data phase
   always_comb begin
      case (bus_state_ff)
         fst_pkg::BUS_WRITE: begin
            wr_now = 1'b1;
         end
         fst_pkg::BUS_READ: begin
            wr_now = 1'b0;
         end
         default: begin
            wr_now = 1'b0;
         end
      endcase
   end

   // Table writes need the permission bit; reads never do
   assign table_wr_ok = wr_now && cfg_ff[fst_pkg::CFG_WR_EN_BIT];

   // One decode per register, shared by storage and read forwarding
   assign wr_cfg = wr_now && (wr_idx_ff == fst_pkg::IDX_CFG);
   assign wr_mode = wr_now && (wr_idx_ff == fst_pkg::IDX_MODE);
   assign wr_ofs = table_wr_ok && (wr_idx_ff == fst_pkg::IDX_TABLE_OFS);
   assign wr_duty9 = table_wr_ok && (wr_idx_ff == fst_pkg::IDX_ENTRY9_DUTY);
   assign wr_limit10 = table_wr_ok && (wr_idx_ff == fst_pkg::IDX_ENTRY10_LIMIT);
   assign wr_duty10 = table_wr_ok && (wr_idx_ff == fst_pkg::IDX_ENTRY10_DUTY);

   // Pipelined masters may read in the write's data phase; forward so no stale word
   always_comb begin
      fwd_cfg = cfg_ff;
      fwd_mode = mode_ff;
      fwd_ofs = table_ofs_ff;
      fwd_duty9 = entry9_duty_ff;
      fwd_limit10 = entry10_limit_ff;
      fwd_duty10 = entry10_duty_ff;
      if (wr_cfg) begin
         fwd_cfg = hwdata[7:0] & fst_pkg::CFG_MASK;
      end
      if (wr_mode) begin
         fwd_mode = hwdata[7:0] & fst_pkg::MODE_MASK;
      end
      if (wr_ofs) begin
         fwd_ofs = hwdata[7:0];
      end
      if (wr_duty9) begin
         fwd_duty9 = hwdata[7:0];
      end
      if (wr_limit10) begin
         fwd_limit10 = hwdata[7:0];
      end
      if (wr_duty10) begin
         fwd_duty10 = hwdata[7:0];
      end
   end

   // Configuration and mode registers, always writable
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_ff <= fst_pkg::RST_CFG;
         mode_ff <= fst_pkg::RST_MODE;
      end else if (wr_now) begin
         if (wr_cfg) begin
            cfg_ff <= hwdata[7:0] & fst_pkg::CFG_MASK;
         end
         if (wr_mode) begin
            mode_ff <= hwdata[7:0] & fst_pkg::MODE_MASK;
         end
      end
   end

   // Table offset register, shared by all limits
   always_ff @(posedge clk) begin
      if (rst) begin
         table_ofs_ff <= fst_pkg::RST_TABLE_OFS;
      end else if (wr_ofs) begin
         table_ofs_ff <= hwdata[7:0];
      end
   end

   // Entry nine duty, all eight bits stored so a mode change keeps them
   always_ff @(posedge clk) begin
      if (rst) begin
         entry9_duty_ff <= fst_pkg::RST_DUTY;
      end else if (wr_duty9) begin
         entry9_duty_ff <= hwdata[7:0];
      end
   end

   // Entry ten limit
   always_ff @(posedge clk) begin
      if (rst) begin
         entry10_limit_ff <= fst_pkg::RST_LIMIT;
      end else if (wr_limit10) begin
         entry10_limit_ff <= hwdata[7:0];
      end
   end

   // Entry ten duty
   always_ff @(posedge clk) begin
      if (rst) begin
         entry10_duty_ff <= fst_pkg::RST_DUTY;
      end else if (wr_duty10) begin
         entry10_duty_ff <= hwdata[7:0];
      end
   end

   // Feed the selector
   assign tbl_if.limit9 = entry9_limit;
   assign tbl_if.limit10 = entry10_limit_ff;
   assign tbl_if.duty9 = entry9_duty_ff;
   assign tbl_if.duty10 = entry10_duty_ff;
   assign tbl_if.table_ofs = table_ofs_ff;
   assign tbl_if.temp_hi = temp_hi;
   assign tbl_if.duty_hi = duty_hi;
   assign tbl_if.pwm_fast = pwm_fast;
   assign tbl_if.remote_temp = remote_temp;

   // Compare and choose the driving entry
   fst_entry_select u_select (
      .tbl (tbl_if.sel)
   );

   // Registered duty out; one cycle behind the inputs, glitch free
   always_ff @(posedge clk) begin
      if (rst) begin
         table_duty_ff <= 8'h00;
         table_duty_hit_ff <= 1'b0;
      end else begin
         table_duty_ff <= tbl_if.duty;
         table_duty_hit_ff <= tbl_if.hit;
      end
   end

   assign table_duty = table_duty_ff;
   assign table_duty_hit = table_duty_hit_ff;

endmodule

// ==== design/fst_pkg.sv ====
// Constants for fan speed table entries nine and ten.
// Assumes word-aligned AHB-Lite access; byte address is four times the index.
package fst_pkg;

   // Register indices (byte address = index * 4)
   localparam logic [7:0] IDX_CFG = 8'h4A;
   localparam logic [7:0] IDX_TABLE_OFS = 8'h4E;
   localparam logic [7:0] IDX_ENTRY9_DUTY = 8'h61;
   localparam logic [7:0] IDX_ENTRY10_LIMIT = 8'h62;
   localparam logic [7:0] IDX_ENTRY10_DUTY = 8'h63;
   localparam logic [7:0] IDX_MODE = 8'h70;

   // Field positions
   localparam int CFG_WR_EN_BIT = 5;
   localparam int MODE_TEMP_HI_BIT = 0;
   localparam int MODE_DUTY_HI_BIT = 1;
   localparam int MODE_PWM_FAST_BIT = 2;
   localparam int LIMIT_HALF_BIT = 7;
   localparam logic [7:0] DUTY_BASE_MASK = 8'h3F;
   localparam logic [7:0] LIMIT_BASE_MASK = 8'h7F;
   localparam logic [7:0] CFG_MASK = 8'h20;
   localparam logic [7:0] MODE_MASK = 8'h07;

   // Reset values
   localparam logic [7:0] RST_DUTY = 8'h3F;
   localparam logic [7:0] RST_LIMIT = 8'h7F;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_TABLE_OFS = 8'h00;

   // Bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic HRESP_OKAY = 1'h0;

   // Data phase of the bus slave
   typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} fst_bus_state_t;

endpackage

// ==== design/fst_entry_if.sv ====
// Carrier between the register bank and the entry selector.
// Assumes both ends run on the same clock; all signals are levels.
`timescale 1ns/1ps
interface fst_entry_if;
   logic [7:0] limit9;
   logic [7:0] limit10;
   logic [7:0] duty9;
   logic [7:0] duty10;
   logic [7:0] table_ofs;
   logic temp_hi;
   logic duty_hi;
   logic pwm_fast;
   logic [10:0] remote_temp;
   logic hit;
   logic [7:0] duty;

   modport regs (output limit9, limit10, duty9, duty10, table_ofs,
                 output temp_hi, duty_hi, pwm_fast, remote_temp,
                 input hit, duty);
   modport sel (input limit9, limit10, duty9, duty10, table_ofs,
                input temp_hi, duty_hi, pwm_fast, remote_temp,
                output hit, duty);
endinterface

// ==== design/fst_entry_select.sv ====
// Combinational compare of the remote reading against entries nine and ten.
// Assumes the register bank supplies stored values and mode bits.
`timescale 1ns/1ps
module fst_entry_select (
   // Table values in, selection out
   fst_entry_if.sel tbl
);

   // Limit in half degrees, table offset added; never negative
   function automatic logic [9:0] eff_limit(input logic [7:0] lim,
                                            input logic [7:0] ofs,
                                            input logic hi);
      logic half;
      half = hi ? lim[fst_pkg::LIMIT_HALF_BIT] : 1'b0;
      eff_limit = {2'h0, lim[6:0], half} + {1'h0, ofs, 1'h0};
   endfunction

   // Duty value with the extended bits only in the fast high mode
   function automatic logic [7:0] duty_val(input logic [7:0] d,
                                           input logic hi,
                                           input logic fast);
      if (hi && fast) begin
         duty_val = d;
      end else begin
         duty_val = d & fst_pkg::DUTY_BASE_MASK;
      end
   endfunction

   logic [9:0] temp_half;
   logic over9;
   logic over10;

   // Nine bits of reading in high resolution, eight in low
   assign temp_half = tbl.temp_hi ? {1'h0, tbl.remote_temp[10:2]}
                                  : {1'h0, tbl.remote_temp[10:3], 1'h0};

   // Strictly greater than the limit
   assign over9 = temp_half > eff_limit(tbl.limit9, tbl.table_ofs, tbl.temp_hi);
   assign over10 = temp_half > eff_limit(tbl.limit10, tbl.table_ofs, tbl.temp_hi);

   // Higher entry wins when both limits are exceeded
   always_comb begin
      tbl.hit = 1'b0;
      tbl.duty = 8'h00;
      if (over10) begin
         tbl.hit = 1'b1;
         tbl.duty = duty_val(tbl.duty10, tbl.duty_hi, tbl.pwm_fast);
      end else if (over9) begin
         tbl.hit = 1'b1;
         tbl.duty = duty_val(tbl.duty9, tbl.duty_hi, tbl.pwm_fast);
      end
   end

endmodule

// ==== verification/fst_checker.sv ====
// Port-level assertions for the fan speed table entries nine and ten.
// Assumes one clock, synchronous reset and hready tied to hreadyout.
`timescale 1ns/1ps
module fst_checker (
   // Clock and reset
   input logic clk,
   input logic rst,
   // Bus
   input logic hsel,
   input logic [31:0] haddr,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic hready,
   input logic hreadyout,
   input logic hresp,
   input logic [31:0] hrdata,
   // Device side
   input logic [10:0] remote_temp,
   input logic [7:0] entry9_limit,
   input logic [7:0] table_duty,
   input logic table_duty_hit
);
   logic tx;
   logic map;
   logic [1:0] q_ff;
   logic [10:0] t_ff;
   logic [7:0] l_ff;
   // Taken transfer and mapped address
   assign tx = hsel && hready && htrans[1];
   assign map = haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0 && haddr[9:2] inside
      {fst_pkg::IDX_CFG, fst_pkg::IDX_TABLE_OFS, fst_pkg::IDX_ENTRY9_DUTY,
       fst_pkg::IDX_ENTRY10_LIMIT, fst_pkg::IDX_ENTRY10_DUTY, fst_pkg::IDX_MODE};
   // Quiet counter; any write may move the duty two edges later
   always_ff @(posedge clk) begin
      t_ff <= remote_temp;
      l_ff <= entry9_limit;
      if (rst || tx || remote_temp != t_ff || entry9_limit != l_ff) begin
         q_ff <= 2'h0;
      end else if (q_ff != 2'h3) begin
         q_ff <= q_ff + 2'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_bus_okay: assert property (hreadyout && hresp == fst_pkg::HRESP_OKAY)
      else $error("bus answer not ready or not okay");
   a_rd_upper: assert property (hrdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_rd_hold: assert property (!(tx && !hwrite) |=> $stable(hrdata))
      else $error("read data moved without a read");
   a_rd_unmap: assert property (tx && !hwrite && !map |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_reset_out: assert property ($fell(rst) |-> table_duty == 8'h00 && !table_duty_hit)
      else $error("outputs not cleared by reset");
   a_nohit_zero: assert property (!table_duty_hit |-> table_duty == 8'h00)
      else $error("duty driven without a hit");
   a_cold_nohit: assert property (remote_temp == 11'h0 |=> !table_duty_hit)
      else $error("hit at zero reading");
   a_out_quiet: assert property (q_ff == 2'h3 && remote_temp == t_ff && entry9_limit == l_ff
      |-> $stable(table_duty) && $stable(table_duty_hit))
      else $error("duty moved with quiet inputs");
endmodule

bind fst_lut_entries fst_checker i_chk (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .remote_temp(remote_temp), .entry9_limit(entry9_limit),
   .table_duty(table_duty), .table_duty_hit(table_duty_hit));

// ==== verification/fst_host_model.sv ====
// Host software model: single word AHB-Lite transfers to the table.
// Assumes callers start a transfer just after a rising clock edge.
`timescale 1ns/1ps
module fst_host_model (
   // Clock
   input logic clk,
   // Master side
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input logic hready,
   input logic [31:0] hrdata
);
   // Idle bus from time zero
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'hFFFFFFFF;
   end
   // One transfer; waits on hready with no assumed latency
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
         output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'h0};
      htrans <= fst_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      hwdata <= ~{24'h0, wd}; // Released data must not look valid
   endtask
endmodule

// ==== verification/fst_lut_entries_tb_top.sv ====
// Self-checking bench for fan speed table entries nine and ten.
// Assumes the host model drives the bus and the bench drives the reading.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch %s exp %0h got %0h", n, e, g); end end
module fst_lut_entries_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [10:0] remote_temp = 11'h0;
   logic [7:0] entry9_limit = 8'h00;
   logic hsel, hwrite, hreadyout, hresp, table_duty_hit;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] table_duty;
   int n_errors = 0;
   int num_checks = 0;
   // Mode, offset, reading, expected duty, expected hit
   localparam logic [31:0] CASES [12] = '{32'h00050000, 32'h00057000, 32'h00058091,
      32'h10054091, 32'h100A4091, 32'h000A4091, 32'h000A80A1, 32'h200A80A1,
      32'h600A8CA1, 32'h60058C91, 32'h010A8091, 32'h010B00A1};
   // 200 MHz clock
   always #2.5 clk = ~clk;
   fst_host_model i_host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
   fst_lut_entries i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .remote_temp(remote_temp),
      .entry9_limit(entry9_limit), .table_duty(table_duty), .table_duty_hit(table_duty_hit));
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      i_host.xfer(1'b1, idx, d, rd);
   endtask
   task automatic rd_chk(input string n, input logic [7:0] idx, input logic [31:0] e);
      i_host.xfer(1'b0, idx, 8'h00, rd);
      `CHK(n, e, rd)
   endtask
   // Reset values and an unmapped word
   task automatic t_reset;
      rd_chk("duty9", fst_pkg::IDX_ENTRY9_DUTY, 32'h3F);
      rd_chk("limit10", fst_pkg::IDX_ENTRY10_LIMIT, 32'h7F);
      rd_chk("duty10", fst_pkg::IDX_ENTRY10_DUTY, 32'h3F);
      rd_chk("unmapped", 8'h64, 32'h0);
   endtask
   // Locked writes ignored, then masks follow the resolution modes
   task automatic t_gate_mask;
      wr(fst_pkg::IDX_ENTRY10_DUTY, 8'h12);
      wr(fst_pkg::IDX_TABLE_OFS, 8'h05);
      rd_chk("locked", fst_pkg::IDX_ENTRY10_DUTY, 32'h3F);
      rd_chk("ofs_locked", fst_pkg::IDX_TABLE_OFS, 32'h0);
      wr(fst_pkg::IDX_CFG, 8'hFF);
      rd_chk("cfg", fst_pkg::IDX_CFG, 32'h20);
      wr(fst_pkg::IDX_ENTRY10_DUTY, 8'hC5);
      wr(fst_pkg::IDX_ENTRY10_LIMIT, 8'hFF);
      rd_chk("duty_lo", fst_pkg::IDX_ENTRY10_DUTY, 32'h05);
      rd_chk("limit_lo", fst_pkg::IDX_ENTRY10_LIMIT, 32'h7F);
      wr(fst_pkg::IDX_MODE, 8'hFB);
      rd_chk("mode", fst_pkg::IDX_MODE, 32'h03);
      rd_chk("duty_hi", fst_pkg::IDX_ENTRY10_DUTY, 32'hC5);
      rd_chk("limit_hi", fst_pkg::IDX_ENTRY10_LIMIT, 32'hFF);
   endtask
   // Boundaries of compare, resolution, priority and offset
   task automatic t_compare;
      logic [31:0] c;
      wr(fst_pkg::IDX_ENTRY9_DUTY, 8'hC9);
      wr(fst_pkg::IDX_ENTRY10_DUTY, 8'hCA);
      wr(fst_pkg::IDX_ENTRY10_LIMIT, 8'h94);
      entry9_limit <= 8'h0A;
      for (int i = 0; i < 12; i++) begin
         c = CASES[i];
         wr(fst_pkg::IDX_MODE, {4'h0, c[31:28]});
         wr(fst_pkg::IDX_TABLE_OFS, {4'h0, c[27:24]});
         remote_temp <= c[22:12];
         repeat (3) @(posedge clk);
         `CHK("duty", c[11:4], table_duty)
         `CHK("hit", c[0], table_duty_hit)
      end
      rd_chk("ofs", fst_pkg::IDX_TABLE_OFS, 32'h01);
   endtask
   // Reset in mid-run: values return, table locks, reset duty nine drives the output
   task automatic t_midreset;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_chk("cfg_rst", fst_pkg::IDX_CFG, 32'h0);
      rd_chk("mode_rst", fst_pkg::IDX_MODE, 32'h0);
      t_reset();
      wr(fst_pkg::IDX_ENTRY9_DUTY, 8'h21);
      rd_chk("relocked", fst_pkg::IDX_ENTRY9_DUTY, 32'h3F);
      `CHK("duty_rst", 8'h3F, table_duty)
      `CHK("hit_rst", 1'b1, table_duty_hit)
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Main sequence after six reset cycles
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_gate_mask();
      t_compare();
      t_midreset();
      final_report();
   end
   // Watchdog, far beyond the roughly 150 cycles the tests need
   initial begin
      #100000;
      n_errors++;
      final_report();
   end
endmodule
